// ===== rtl/phy_mgmt_pkg.sv
package phy_mgmt_pkg;

	localparam int          CLK_PERIOD_NS = 50;
	localparam int          POWER_UP_US   = 300;
	localparam int          READY_CYCLES  = POWER_UP_US * 1000 / CLK_PERIOD_NS;

	localparam logic [4:0]  ADDR_CONTROL      = 5'h00;
	localparam logic [4:0]  ADDR_STATUS       = 5'h01;
	localparam logic [4:0]  ADDR_IDENT_HIGH   = 5'h02;
	localparam logic [4:0]  ADDR_IDENT_LOW    = 5'h03;
	localparam logic [4:0]  ADDR_ADVERTISE    = 5'h04;
	localparam logic [4:0]  ADDR_PARTNER_BASE = 5'h05;
	localparam logic [4:0]  ADDR_EXPANSION    = 5'h06;
	localparam logic [4:0]  ADDR_NP_TRANSMIT  = 5'h07;
	localparam logic [4:0]  ADDR_PARTNER_NP   = 5'h08;

	localparam logic [15:0] ADV_RESET     = 16'h0001;
	localparam logic [15:0] NP_TX_RESET   = 16'h0000;

	localparam int          PREAMBLE_LEN  = 32;
	localparam logic [1:0]  OP_READ       = 2'h2;
	localparam logic [1:0]  OP_WRITE      = 2'h1;
	localparam logic [3:0]  HDR_LAST      = 4'hB;
	localparam logic [3:0]  DATA_LAST     = 4'hF;

	typedef struct packed {
		logic       soft_reset;
		logic       loopback;
		logic       speed_lsb;
		logic       an_enable;
		logic       power_down;
		logic       isolate;
		logic       an_restart;
		logic       full_duplex;
		logic       col_test;
		logic       speed_msb;
		logic [5:0] reserved;
	} phy_ctrl_t;

	typedef struct packed {
		logic       speed_100;
		logic       an_enable;
		logic       full_duplex;
		logic [4:0] phy_addr;
	} strap_t;

	typedef enum logic [4:0] {
		ST_PRE   = 5'b00001,
		ST_START = 5'b00010,
		ST_HDR   = 5'b00100,
		ST_TA    = 5'b01000,
		ST_DATA  = 5'b10000
	} frame_state_t;

endpackage

// ===== rtl/mgmt_ready_timer.sv
`timescale 1ns/1ns
`default_nettype none
module mgmt_ready_timer #(
	parameter int CYCLES = 6000
) (
	input  wire logic clk_i,
	input  wire logic arst_n_i,
	output logic      ready_o
);
	localparam int W = $clog2(CYCLES + 2);

	logic [W-1:0] cnt_ff;
	logic [W-1:0] age_ff;

	if (CYCLES < 1) begin : g_bad
		$error("CYCLES must be at least 1");
	end

	// counts from release of the asynchronous reset only; ready never before the full delay
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_ff  <= '0;
			ready_o <= 1'b0;
		end else if (!ready_o) begin
			cnt_ff <= cnt_ff + W'(1);
			if (cnt_ff == W'(CYCLES - 1)) begin
				ready_o <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			age_ff <= '0;
		end else if (age_ff != W'(CYCLES + 1)) begin
			age_ff <= age_ff + W'(1);
		end
	end

	property p_ready_on_time;
		@(posedge clk_i) disable iff (!arst_n_i)
		$rose(ready_o) |-> age_ff == W'(CYCLES);
	endproperty
	a_ready_on_time: assert property (p_ready_on_time) else $error("ready at wrong time");

	property p_ready_held;
		@(posedge clk_i) disable iff (!arst_n_i)
		(age_ff == W'(CYCLES + 1)) |-> ready_o;
	endproperty
	a_ready_held: assert property (p_ready_held) else $error("not ready after delay");

	c_ready: cover property (@(posedge clk_i) disable iff (!arst_n_i) $rose(ready_o));
endmodule
`default_nettype wire

// ===== rtl/phy_mgmt_regs.sv
`timescale 1ns/1ns
`default_nettype none
module phy_mgmt_regs #(
	parameter int          READY_CYCLES = phy_mgmt_pkg::READY_CYCLES,
	parameter logic [15:0] ID_HIGH      = 16'hA5C3, // arbitrary value
	parameter logic [15:0] ID_LOW       = 16'h5A10  // arbitrary value
) (
	input  wire logic                 CLK_I,
	input  wire logic                 ARST_N_I,
	input  wire logic                 MDC_I,
	input  wire logic                 MDIO_I,
	output logic                      MDIO_O,
	output logic                      MDIO_OE_O,
	input  wire phy_mgmt_pkg::strap_t STRAP_I,
	input  wire logic [15:0]          STATUS_I,
	input  wire logic [15:0]          PARTNER_BASE_I,
	input  wire logic [15:0]          EXPANSION_I,
	input  wire logic [15:0]          PARTNER_NP_I,
	output phy_mgmt_pkg::phy_ctrl_t   CTRL_O,
	output logic [15:0]               ADV_O,
	output logic [15:0]               NP_TX_O,
	output logic                      SOFT_RESET_O,
	output logic                      AN_RESTART_O,
	output logic                      READY_O
);
	import phy_mgmt_pkg::*;

	logic         mdc_s1_ff;
	logic         mdc_s2_ff;
	logic         mdc_d_ff;
	logic         mdio_s1_ff;
	logic         mdio_s2_ff;
	strap_t       strap_s1_ff;
	strap_t       strap_s2_ff;
	frame_state_t state_ff;
	logic [5:0]   ones_ff;
	logic [3:0]   cnt_ff;
	logic [11:0]  hdr_ff;
	logic [15:0]  shift_ff;
	logic [4:0]   phy_addr_ff;
	logic         mdc_rise;
	logic         bit_in;
	logic         is_read;
	logic         is_write;
	logic         match;
	logic [4:0]   reg_addr;
	logic         wr_commit;
	logic         ta_load;
	logic [15:0]  wdata;
	logic [15:0]  rd_word;
	phy_ctrl_t    ctrl_default;
	phy_ctrl_t    ctrl_wr;

	mgmt_ready_timer #(.CYCLES(READY_CYCLES)) u_timer (
		.clk_i    (CLK_I),
		.arst_n_i (ARST_N_I),
		.ready_o  (READY_O)
	);

	// mdc is only 8x slower than our clock at its fastest; edges still resolve
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			mdc_s1_ff   <= 1'b0;
			mdc_s2_ff   <= 1'b0;
			mdc_d_ff    <= 1'b0;
			mdio_s1_ff  <= 1'b1;
			mdio_s2_ff  <= 1'b1;
			strap_s1_ff <= '0;
			strap_s2_ff <= '0;
		end else begin
			mdc_s1_ff   <= MDC_I;
			mdc_s2_ff   <= mdc_s1_ff;
			mdc_d_ff    <= mdc_s2_ff;
			mdio_s1_ff  <= MDIO_I;
			mdio_s2_ff  <= mdio_s1_ff;
			strap_s1_ff <= STRAP_I;
			strap_s2_ff <= strap_s1_ff;
		end
	end

	assign mdc_rise  = mdc_s2_ff & ~mdc_d_ff;
	assign bit_in    = mdio_s2_ff;
	assign is_read   = (hdr_ff[11:10] == OP_READ);
	assign is_write  = (hdr_ff[11:10] == OP_WRITE);
	assign match     = (hdr_ff[9:5] == phy_addr_ff);
	assign reg_addr  = hdr_ff[4:0];
	assign wdata     = {shift_ff[14:0], bit_in};
	assign wr_commit = mdc_rise && (state_ff == ST_DATA) && (cnt_ff == DATA_LAST)
		&& is_write && match;
	assign ta_load   = mdc_rise && (state_ff == ST_TA) && (cnt_ff == 4'h1) && is_read && match;

	always_comb begin
		case (reg_addr)
			ADDR_CONTROL:      rd_word = CTRL_O;
			ADDR_STATUS:       rd_word = STATUS_I;
			ADDR_IDENT_HIGH:   rd_word = ID_HIGH;
			ADDR_IDENT_LOW:    rd_word = ID_LOW;
			ADDR_ADVERTISE:    rd_word = ADV_O;
			ADDR_PARTNER_BASE: rd_word = PARTNER_BASE_I;
			ADDR_EXPANSION:    rd_word = EXPANSION_I;
			ADDR_NP_TRANSMIT:  rd_word = NP_TX_O;
			ADDR_PARTNER_NP:   rd_word = PARTNER_NP_I;
			default:           rd_word = 16'h0000;
		endcase
	end

	always_comb begin
		ctrl_default             = '0;
		ctrl_default.speed_lsb   = strap_s2_ff.speed_100;
		ctrl_default.an_enable   = strap_s2_ff.an_enable;
		ctrl_default.full_duplex = strap_s2_ff.full_duplex;
		ctrl_wr                  = phy_ctrl_t'(wdata);
		ctrl_wr.soft_reset       = 1'b0;
		ctrl_wr.an_restart       = 1'b0;
		ctrl_wr.speed_msb        = 1'b0;
	end

	// frames are ignored entirely until the start-up delay has run out
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			state_ff <= ST_PRE;
			ones_ff  <= '0;
			cnt_ff   <= '0;
			hdr_ff   <= '0;
			shift_ff <= '0;
		end else if (!READY_O) begin
			state_ff <= ST_PRE;
			ones_ff  <= '0;
		end else if (mdc_rise) begin
			case (state_ff)
				ST_PRE: begin
					if (bit_in) begin
						if (ones_ff != 6'(PREAMBLE_LEN))
							ones_ff <= ones_ff + 6'h01;
					end else begin
						ones_ff <= '0;
						if (ones_ff == 6'(PREAMBLE_LEN))
							state_ff <= ST_START;
					end
				end
				ST_START: begin
					cnt_ff   <= '0;
					state_ff <= bit_in ? ST_HDR : ST_PRE;
				end
				ST_HDR: begin
					hdr_ff <= {hdr_ff[10:0], bit_in};
					cnt_ff <= cnt_ff + 4'h1;
					if (cnt_ff == HDR_LAST) begin
						cnt_ff   <= '0;
						state_ff <= ST_TA;
					end
				end
				ST_TA: begin
					cnt_ff <= cnt_ff + 4'h1;
					if (cnt_ff == 4'h1) begin
						cnt_ff   <= '0;
						shift_ff <= {rd_word[14:0], 1'b0};
						state_ff <= ST_DATA;
					end
				end
				ST_DATA: begin
					shift_ff <= wdata;
					cnt_ff   <= cnt_ff + 4'h1;
					if (cnt_ff == DATA_LAST)
						state_ff <= ST_PRE;
				end
				default: state_ff <= ST_PRE;
			endcase
		end
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			MDIO_O    <= 1'b0;
			MDIO_OE_O <= 1'b0;
		end else if (!READY_O) begin
			MDIO_OE_O <= 1'b0;
		end else if (mdc_rise) begin
			if (state_ff == ST_TA && cnt_ff == 4'h0 && is_read && match) begin
				MDIO_OE_O <= 1'b1;
				MDIO_O    <= 1'b0;
			end else if (ta_load) begin
				MDIO_O <= rd_word[15];
			end else if (state_ff == ST_DATA) begin
				MDIO_O <= shift_ff[15];
				if (cnt_ff == DATA_LAST)
					MDIO_OE_O <= 1'b0;
			end
		end
	end

	// straps are tracked until ready, so the last synchronised value is the default
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			CTRL_O       <= '0;
			ADV_O        <= ADV_RESET;
			NP_TX_O      <= NP_TX_RESET;
			phy_addr_ff  <= '0;
			SOFT_RESET_O <= 1'b0;
			AN_RESTART_O <= 1'b0;
		end else begin
			SOFT_RESET_O <= 1'b0;
			AN_RESTART_O <= 1'b0;
			if (!READY_O) begin
				CTRL_O      <= ctrl_default;
				phy_addr_ff <= strap_s2_ff.phy_addr;
			end else if (wr_commit) begin
				case (reg_addr)
					ADDR_CONTROL: begin
						if (wdata[15]) begin
							CTRL_O       <= ctrl_default;
							ADV_O        <= ADV_RESET;
							NP_TX_O      <= NP_TX_RESET;
							SOFT_RESET_O <= 1'b1;
						end else begin
							CTRL_O       <= ctrl_wr;
							AN_RESTART_O <= wdata[9];
						end
					end
					ADDR_ADVERTISE:   ADV_O   <= wdata;
					ADDR_NP_TRANSMIT: NP_TX_O <= wdata;
					default: ;
				endcase
			end
		end
	end

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!ARST_N_I);

	property p_ctrl_write;
		(wr_commit && reg_addr == ADDR_CONTROL && !wdata[15])
			|=> CTRL_O == ($past(wdata) & 16'h7DBF);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

	property p_status_read;
		(ta_load && reg_addr == ADDR_STATUS) |=> MDIO_O == $past(STATUS_I[15]) && MDIO_OE_O;
	endproperty
	a_status_read: assert property (p_status_read) else $error("status read wrong");

	property p_absent_write;
		(wr_commit && reg_addr > ADDR_PARTNER_NP) |=> $stable(CTRL_O) && $stable(ADV_O)
			&& $stable(NP_TX_O);
	endproperty
	a_absent_write: assert property (p_absent_write) else $error("absent address stored");

	property p_no_gig;
		READY_O && $past(READY_O) |-> CTRL_O.speed_msb == 1'b0;
	endproperty
	a_no_gig: assert property (p_no_gig) else $error("speed bit 6 set");

	property p_strap_default;
		!READY_O ##1 READY_O |-> CTRL_O.an_enable == $past(strap_s2_ff.an_enable)
			&& CTRL_O.full_duplex == $past(strap_s2_ff.full_duplex)
			&& CTRL_O.speed_lsb == $past(strap_s2_ff.speed_100);
	endproperty
	a_strap_default: assert property (p_strap_default) else $error("strap default wrong");

	property p_soft_reset;
		(wr_commit && reg_addr == ADDR_CONTROL && wdata[15])
			|=> SOFT_RESET_O && !CTRL_O.soft_reset ##1 !SOFT_RESET_O;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset wrong");

	property p_restart;
		(wr_commit && reg_addr == ADDR_CONTROL && !wdata[15] && wdata[9])
			|=> AN_RESTART_O && !CTRL_O.an_restart ##1 !AN_RESTART_O;
	endproperty
	a_restart: assert property (p_restart) else $error("restart pulse wrong");

	property p_quiet_before_ready;
		!READY_O |=> !MDIO_OE_O;
	endproperty
	a_quiet_before_ready: assert property (p_quiet_before_ready) else $error("drove early");

	c_read:  cover property (ta_load);
	c_write: cover property (wr_commit && reg_addr == ADDR_CONTROL);
	c_soft:  cover property (SOFT_RESET_O);
endmodule
`default_nettype wire

// ===== tb/mdio_station.sv
`timescale 1ns/1ns
`default_nettype none
module mdio_station (
	input  wire logic clk_i,
	input  wire logic mdio_i,
	output logic      mdc_o,
	output logic      mdio_o,
	output logic      mdio_oe_o
);
	localparam logic [1:0] OP_RD = 2'h2;
	initial begin
		mdc_o = 1'b0;
		mdio_o = 1'b1;
		mdio_oe_o = 1'b0;
	end
	// mdc stands low between frames; 4 clocks per half period keeps the device's 3-clock floor
	task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, output logic [16:0] rd);
		logic [63:0] bits;
		bits = {32'hFFFFFFFF, 2'b01, op, pa, ra, 2'b10, wd};
		if (ra == 5'h00)
			bits[5:0] = 6'h00;
		for (int i = 63; i >= 0; i--) begin
			@(posedge clk_i);
			mdc_o <= 1'b0;
			mdio_o <= bits[i];
			mdio_oe_o <= !(op == OP_RD && i < 18);
			repeat (3) @(posedge clk_i);
			@(negedge clk_i);
			rd = {rd[15:0], mdio_i};
			@(posedge clk_i);
			mdc_o <= 1'b1;
			repeat (3) @(posedge clk_i);
		end
		@(posedge clk_i);
		mdc_o <= 1'b0;
		mdio_oe_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
	import phy_mgmt_pkg::*;
	localparam int          RC  = 20;
	localparam logic [4:0]  PA  = 5'h03;
	localparam logic [15:0] IDH = 16'h1C2B; // arbitrary value
	localparam logic [15:0] IDL = 16'h6D4E; // arbitrary value
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        mdc, sta_o, sta_oe, dev_o, dev_oe, sr, ar, rdy, mdio_w;
	strap_t      strap;
	phy_ctrl_t   ctrl;
	logic [15:0] status, pbase, expn, pnp, adv, nptx;
	logic [16:0] v;
	int          n_fail = 0;
	int          tests_run = 0;
	int          n_sr = 0;
	int          n_ar = 0;
	logic [15:0] exp_tab [16];
	logic [15:0] ctrl_w [4];
	logic [15:0] ctrl_e [4];
	always #25 clk = ~clk;
	// pull-up holds the line high when nobody drives
	assign mdio_w = dev_oe ? dev_o : (sta_oe ? sta_o : 1'b1);
	phy_mgmt_regs #(.READY_CYCLES(RC), .ID_HIGH(IDH), .ID_LOW(IDL)) phy_mgmt_regs_i (
		.CLK_I(clk), .ARST_N_I(arst_n), .MDC_I(mdc), .MDIO_I(mdio_w), .MDIO_O(dev_o),
		.MDIO_OE_O(dev_oe), .STRAP_I(strap), .STATUS_I(status), .PARTNER_BASE_I(pbase),
		.EXPANSION_I(expn), .PARTNER_NP_I(pnp), .CTRL_O(ctrl), .ADV_O(adv), .NP_TX_O(nptx),
		.SOFT_RESET_O(sr), .AN_RESTART_O(ar), .READY_O(rdy));
	mdio_station mdio_station_i (.clk_i(clk), .mdio_i(mdio_w), .mdc_o(mdc), .mdio_o(sta_o),
		.mdio_oe_o(sta_oe));
	always @(posedge clk) begin
		if (sr === 1'b1)
			n_sr <= n_sr + 1;
		if (ar === 1'b1)
			n_ar <= n_ar + 1;
	end
	task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		mdio_station_i.frame(OP_WRITE, PA, ra, d, v);
		// pulse counters update on the edge the frame ends on; look once settled
		@(negedge clk);
	endtask
	task automatic rc(input logic [4:0] ra, input logic [15:0] e);
		mdio_station_i.frame(OP_READ, PA, ra, 16'h0000, v);
		check($sformatf("reg %0d", ra), v, {1'b0, e});
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk);
		n_fail++;
		summarize();
	end
	initial begin
		status = 16'h7809;
		pbase = 16'h45E1;
		expn = 16'h0005;
		pnp = 16'h2801;
		strap = '{1'b1, 1'b1, 1'b0, PA};
		exp_tab = '{0: 16'h3000, 1: 16'h7809, 2: IDH, 3: IDL, 4: ADV_RESET, 5: 16'h45E1,
			6: 16'h0005, 7: NP_TX_RESET, 8: 16'h2801, default: 16'h0000};
		ctrl_w = '{16'h7DC0, 16'h0000, 16'h2100, 16'h0040};
		ctrl_e = '{16'h7D80, 16'h0000, 16'h2100, 16'h0000};
		repeat (6) @(posedge clk);
		@(negedge clk);
		check("adv in reset", {1'b0, adv}, 17'h00001);
		check("oe in reset", {16'h0000, dev_oe}, 17'h0);
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		repeat (RC - 2) @(posedge clk);
		@(negedge clk);
		check("ready early", {16'h0000, rdy}, 17'h0);
		repeat (3) @(posedge clk);
		@(negedge clk);
		check("ready", {16'h0000, rdy}, 17'h1);
		check("ctrl straps", {1'b0, ctrl}, 17'h03000);
		// first frame only once ready is seen
		for (int a = 0; a < 16; a++)
			rc(a[4:0], exp_tab[a]);
		wr(ADDR_ADVERTISE, 16'hA5E1);
		check("adv", {1'b0, adv}, 17'h0A5E1);
		rc(ADDR_ADVERTISE, 16'hA5E1);
		wr(ADDR_NP_TRANSMIT, 16'h2A5B);
		check("np tx", {1'b0, nptx}, 17'h02A5B);
		wr(ADDR_STATUS, 16'hFFFF);
		rc(ADDR_STATUS, 16'h7809);
		wr(5'h09, 16'hFFFF);
		rc(5'h09, 16'h0000);
		for (int k = 0; k < 4; k++) begin
			wr(ADDR_CONTROL, ctrl_w[k]);
			check("ctrl", {1'b0, ctrl}, {1'b0, ctrl_e[k]});
			rc(ADDR_CONTROL, ctrl_e[k]);
		end
		wr(ADDR_CONTROL, 16'h1200);
		check("restart pulses", n_ar[16:0], 17'h1);
		rc(ADDR_CONTROL, 16'h1000);
		// foreign read must leave the line undriven; foreign write and bad opcode must leave state intact
		mdio_station_i.frame(OP_READ, PA + 5'h01, ADDR_CONTROL, 16'h0000, v);
		check("foreign read", v, 17'h1FFFF);
		mdio_station_i.frame(OP_WRITE, PA + 5'h01, ADDR_ADVERTISE, 16'h0F0F, v);
		mdio_station_i.frame(2'h0, PA, ADDR_ADVERTISE, 16'h0F0F, v);
		rc(ADDR_ADVERTISE, 16'hA5E1);
		wr(ADDR_CONTROL, 16'h8000);
		check("soft reset pulses", n_sr[16:0], 17'h1);
		check("restart after reset", n_ar[16:0], 17'h1);
		rc(ADDR_CONTROL, 16'h3000);
		rc(ADDR_ADVERTISE, ADV_RESET);
		rc(ADDR_NP_TRANSMIT, NP_TX_RESET);
		summarize();
	end
endmodule
`default_nettype wire
